// ### logic/exec_subset.sv
/*
 * instruction subset executor with an axi4-lite slave for commands and state
 * assumes one clock, synchronous active-low reset, a well-behaved axi4-lite master
 */
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
// Function
// - return pops stack, loads pc from stack head, two cycles, flags kept
// - halt clears watchdog and prescaler, sets timeout flag, clears powerdown flag
// - after halt the core sleeps and stops executing
// - literal minus accumulator into accumulator, updates carry, digit carry, zero
// - literal xor accumulator into accumulator, updates zero only
// - file minus accumulator, 7-bit file address, updates carry, digit carry, zero
// - file xor accumulator to chosen destination, updates zero only
// - nibble exchange of file register to destination, no flag changes
// - destination bit 0 selects accumulator, 1 selects file register
`timescale 1ns/100ps
`default_nettype none
`include "exec_subset_map.svh"
module exec_subset (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic osc_run,
    output logic [12:0] pc_out
);
    // register map, byte addresses, one 32-bit word each:
    // 0x00 command: op [3:0], destination [4], file address [14:8], literal [23:16]
    // 0x04 accumulator [7:0]
    // 0x08 status: carry, digit carry, zero, powerdown, timeout, sleep, busy from bit 0 up
    // 0x0c file window: write puts [7:0] at file [14:8], read gives the last command's file
    // 0x10 stack: write pushes [12:0], read gives watchdog [15:8] and stack pointer [2:0]
    // 0x14 program counter [12:0]
    // 0x18 wake: write leaves sleep, read gives the prescaler
    // unmapped addresses answer with a decode error, a refused command with a slave error
    exec_subset_pkg::state_t s_reg;
    exec_subset_pkg::state_t s_next;
    // file registers and return stack are memories, written through one port each
    logic [7:0] file_mem [0:127];
    logic [12:0] stack_mem [0:7];
    logic file_we;
    logic [6:0] file_wa;
    logic [7:0] file_wd;
    logic stack_we;
    logic [2:0] stack_wa;
    logic [12:0] stack_wd;

    // combined next-state logic: bus slave plus executor
    always_comb begin
        logic [8:0] diff;
        logic [4:0] ldiff;
        logic [7:0] opa;
        logic [7:0] res;
        logic [7:0] fval;
        logic [31:0] wd;
        s_next = s_reg;
        diff = 9'h000;
        ldiff = 5'h00;
        opa = 8'h00;
        res = 8'h00;
        fval = file_mem[s_reg.faddr];
        wd = s_reg.wdata;
        // no memory write unless a register write or a result asks for one
        file_we = 1'b0;
        file_wa = s_reg.faddr;
        file_wd = 8'h00;
        stack_we = 1'b0;
        stack_wa = s_reg.sp;
        stack_wd = 13'h0000;
        // write channel capture
        if (s_reg.awready && s_axi_awvalid) begin
            s_next.awready = 1'b0;
            s_next.have_aw = 1'b1;
            s_next.awaddr = s_axi_awaddr;
        end
        if (s_reg.wready && s_axi_wvalid) begin
            s_next.wready = 1'b0;
            s_next.have_w = 1'b1;
            s_next.wdata = s_axi_wdata;
            s_next.wstrb = s_axi_wstrb;
        end
        // response taken: address and data channels open again
        if (s_reg.bvalid && s_axi_bready) begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // execute register write once both halves are held
        if (s_reg.have_aw && s_reg.have_w && !s_reg.bvalid) begin
            s_next.have_aw = 1'b0;
            s_next.have_w = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = 2'h0;
            // decode of the register written
            case (s_reg.awaddr)
                `ADDR_CMD: begin
                    if (s_reg.phase == exec_subset_pkg::ST_IDLE && s_reg.wstrb != 4'h0) begin
                        s_next.op = wd[`CMD_OP_LSB +: 4];
                        s_next.dest = wd[`CMD_DEST_BIT];
                        s_next.faddr = wd[`CMD_FADDR_LSB +: 7];
                        s_next.lit = wd[`CMD_LIT_LSB +: 8];
                        s_next.phase = exec_subset_pkg::ST_EXEC;
                        s_next.cyc = 2'h0;
                    end else begin
                        s_next.bresp = 2'h2; // busy, asleep or no byte strobe
                    end
                end
                `ADDR_ACC: s_next.acc = wd[7:0];
                `ADDR_FILE_WIN: begin
                    file_we = 1'b1;
                    file_wa = wd[14:8];
                    file_wd = wd[7:0];
                end
                `ADDR_STACK: begin
                    // push: the stack wraps after eight entries
                    stack_we = 1'b1;
                    stack_wa = s_reg.sp;
                    stack_wd = wd[12:0];
                    s_next.sp = s_reg.sp + 3'h1;
                end
                `ADDR_PC: s_next.pc = wd[12:0];
                `ADDR_WAKE: begin
                    // only a sleeping core has anything to leave
                    if (s_reg.phase == exec_subset_pkg::ST_SLEEP) begin
                        s_next.phase = exec_subset_pkg::ST_IDLE;
                    end
                end
                `ADDR_STATUS: begin
                    // software may preset the three arithmetic flags only
                    s_next.c = wd[`ST_C];
                    s_next.dc = wd[`ST_DC];
                    s_next.z = wd[`ST_Z];
                end
                default: s_next.bresp = 2'h3;
            endcase
        end
        // read channel
        if (s_reg.rvalid && s_axi_rready) begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
        // address taken: the registered view answers one edge later
        if (s_reg.arready && s_axi_arvalid) begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = 2'h0;
            s_next.rdata = 32'h00000000;
            case (s_axi_araddr)
                `ADDR_CMD: s_next.rdata = {8'h00, s_reg.lit, 1'b0, s_reg.faddr, 3'h0, s_reg.dest, s_reg.op};
                `ADDR_ACC: s_next.rdata = {24'h000000, s_reg.acc};
                `ADDR_STATUS: s_next.rdata = {25'h0000000, s_reg.phase != exec_subset_pkg::ST_IDLE,
                    s_reg.phase == exec_subset_pkg::ST_SLEEP, s_reg.to_n, s_reg.pd_n, s_reg.z, s_reg.dc, s_reg.c};
                `ADDR_FILE_WIN: s_next.rdata = {24'h000000, fval};
                `ADDR_STACK: s_next.rdata = {16'h0000, s_reg.wdt, 5'h00, s_reg.sp};
                `ADDR_PC: s_next.rdata = {19'h00000, s_reg.pc};
                `ADDR_WAKE: s_next.rdata = {24'h000000, s_reg.presc};
                default: s_next.rresp = 2'h3;
            endcase
        end
        // free-running watchdog while awake
        if (s_reg.phase != exec_subset_pkg::ST_SLEEP) begin
            s_next.presc = s_reg.presc + 8'h01;
            if (s_reg.presc == 8'hff) s_next.wdt = s_reg.wdt + 8'h01;
        end
        // instruction execution
        if (s_reg.phase == exec_subset_pkg::ST_EXEC) begin
            s_next.phase = exec_subset_pkg::ST_IDLE;
            s_next.pc = s_reg.pc + 13'h0001;
            opa = (s_reg.op == `OP_LIT_MINUS_ACC || s_reg.op == `OP_XOR_LIT_ACC) ? s_reg.lit : fval;
            // both subtractions share one nine-bit and one five-bit subtractor
            diff = {1'b0, opa} - {1'b0, s_reg.acc};
            ldiff = {1'b0, opa[3:0]} - {1'b0, s_reg.acc[3:0]};
            // each instruction updates only its own flags, the rest keep their value
            case (s_reg.op)
                `OP_RETURN: begin
                    // second cycle loads pc from stack head
                    if (s_reg.cyc == `CYC_ONE_CYCLE) begin
                        s_next.pc = stack_mem[s_reg.sp - 3'h1];
                        s_next.sp = s_reg.sp - 3'h1;
                    end else begin
                        s_next.pc = s_reg.pc;
                        s_next.cyc = s_reg.cyc + 2'h1;
                        s_next.phase = exec_subset_pkg::ST_EXEC;
                    end
                end
                `OP_HALT: begin
                    // clear the watchdog chain and mark the power-down entry
                    s_next.wdt = `RST_WDT;
                    s_next.presc = `RST_PRESC;
                    s_next.to_n = 1'b1;
                    s_next.pd_n = 1'b0;
                    s_next.phase = exec_subset_pkg::ST_SLEEP;
                end
                `OP_LIT_MINUS_ACC, `OP_FILE_MINUS_ACC: begin
                    // carries are inverted borrows
                    res = diff[7:0];
                    s_next.c = ~diff[8];
                    s_next.dc = ~ldiff[4];
                    s_next.z = (res == 8'h00);
                end
                `OP_XOR_LIT_ACC, `OP_XOR_FILE_ACC: begin
                    // carry and digit carry are left alone
                    res = s_reg.acc ^ opa;
                    s_next.z = (res == 8'h00);
                end
                `OP_NIBBLE_EXCHANGE: begin
                    // no flag is touched by the exchange
                    res = {fval[3:0], fval[7:4]};
                end
                default: res = 8'h00;
            endcase
            // destination routing
            // literal forms always write the accumulator
            if (s_reg.op == `OP_LIT_MINUS_ACC || s_reg.op == `OP_XOR_LIT_ACC) begin
                s_next.acc = res;
            end else if (s_reg.op == `OP_FILE_MINUS_ACC || s_reg.op == `OP_XOR_FILE_ACC
                    || s_reg.op == `OP_NIBBLE_EXCHANGE) begin
                if (s_reg.dest) begin
                    file_we = 1'b1;
                    file_wa = s_reg.faddr;
                    file_wd = res;
                end else begin
                    s_next.acc = res;
                end
            end
        end
        // synchronous reset of control state
        // file registers and stack contents are left as they are
        if (!aresetn) begin
            s_next.phase = exec_subset_pkg::ST_IDLE;
            s_next.cyc = 2'h0;
            s_next.op = 4'h0;
            s_next.dest = 1'b0;
            s_next.faddr = 7'h00;
            s_next.lit = 8'h00;
            s_next.acc = `RST_ACC;
            s_next.c = 1'b0;
            s_next.dc = 1'b0;
            s_next.z = 1'b0;
            s_next.to_n = 1'b1;
            s_next.pd_n = 1'b1;
            s_next.wdt = `RST_WDT;
            s_next.presc = `RST_PRESC;
            s_next.pc = `RST_PC;
            s_next.sp = 3'h0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
            s_next.bvalid = 1'b0;
            s_next.arready = 1'b1;
            s_next.rvalid = 1'b0;
            s_next.rdata = 32'h00000000;
            s_next.bresp = 2'h0;
            s_next.rresp = 2'h0;
            s_next.have_aw = 1'b0;
            s_next.have_w = 1'b0;
            s_next.awaddr = 8'h00;
            s_next.wdata = 32'h00000000;
            s_next.wstrb = 4'h0;
            file_we = 1'b0;
            stack_we = 1'b0;
        end
        // oscillator level registered so the pin comes straight from a flop
        s_next.awake = (s_next.phase != exec_subset_pkg::ST_SLEEP);
    end

    // state register and the two memories
    always_ff @(posedge aclk) begin
        s_reg <= s_next;
        if (file_we) begin
            file_mem[file_wa] <= file_wd;
        end
        if (stack_we) begin
            stack_mem[stack_wa] <= stack_wd;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = s_reg.awready;
    assign s_axi_wready = s_reg.wready;
    assign s_axi_bvalid = s_reg.bvalid;
    assign s_axi_bresp = s_reg.bresp;
    assign s_axi_arready = s_reg.arready;
    assign s_axi_rvalid = s_reg.rvalid;
    assign s_axi_rdata = s_reg.rdata;
    assign s_axi_rresp = s_reg.rresp;
    // oscillator level and program counter for the neighbouring core logic
    assign osc_run = s_reg.awake;
    assign pc_out = s_reg.pc;
endmodule // exec_subset
`default_nettype wire

// ### logic/exec_subset_map.svh
/*
 * constants of the instruction subset executor: operation codes, register offsets, field positions and reset values
 * assumes inclusion by the package, the executor and its bench; guarded against double inclusion
 */
`ifndef EXEC_SUBSET_MAP_SVH
`define EXEC_SUBSET_MAP_SVH
// operation codes written to the command register
`define OP_RETURN 4'h1
`define OP_HALT 4'h2
`define OP_LIT_MINUS_ACC 4'h3
`define OP_XOR_LIT_ACC 4'h4
`define OP_FILE_MINUS_ACC 4'h5
`define OP_XOR_FILE_ACC 4'h6
`define OP_NIBBLE_EXCHANGE 4'h7
// register byte addresses
`define ADDR_CMD 8'h00
`define ADDR_ACC 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_FILE_WIN 8'h0c
`define ADDR_STACK 8'h10
`define ADDR_PC 8'h14
`define ADDR_WAKE 8'h18
// command register fields
`define CMD_OP_LSB 0
`define CMD_DEST_BIT 4
`define CMD_FADDR_LSB 8
`define CMD_LIT_LSB 16
// status register fields
`define ST_C 0
`define ST_DC 1
`define ST_Z 2
`define ST_PD 3
`define ST_TO 4
`define ST_SLEEP 5
`define ST_BUSY 6
// reset values
`define RST_ACC 8'h00
`define RST_PC 13'h0000
`define RST_WDT 8'h00
`define RST_PRESC 8'h00
// cycle counts
`define CYC_TWO_CYCLE 2'h2
`define CYC_ONE_CYCLE 2'h1
`endif

// ### logic/exec_subset_pkg.sv
/*
 * types of the instruction subset executor
 * assumes the map header is on the include path
 */
`default_nettype none
`include "exec_subset_map.svh"
package exec_subset_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SLEEP} phase_t;
    typedef struct packed {
        phase_t phase;
        logic [1:0] cyc;
        logic [3:0] op;
        logic dest;
        logic [6:0] faddr;
        logic [7:0] lit;
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic to_n;
        logic pd_n;
        logic [7:0] wdt;
        logic [7:0] presc;
        logic [12:0] pc;
        logic [2:0] sp;
        logic awready;
        logic wready;
        logic bvalid;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] bresp;
        logic [1:0] rresp;
        logic have_aw;
        logic have_w;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awake;
    } state_t;
endpackage
`default_nettype wire

// ### sim/exec_subset_props.sv
/* checker for the instruction subset executor: register bus answers, sleep and reset behaviour at the ports
   assumes binding into exec_subset with one clock and a synchronous active-low reset */
`timescale 1ns/100ps
`default_nettype none
module exec_subset_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic osc_run,
    input wire logic [12:0] pc_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // responses stand until taken, answers come in bounded time
    a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped or changed");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped or changed");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
    a_ready_held_low: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("ready high with response pending");
    a_unmapped_write: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 8'h18
        |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == 2'h3)) else $error("unmapped write not refused");
    a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h18 |=> s_axi_rresp == 2'h3)
        else $error("unmapped read not refused");
    // sleep freezes execution and is entered or left only by a register write
    a_sleep_pc_frozen: assert property (!osc_run && !$past(osc_run) |-> $stable(pc_out))
        else $error("pc moved in sleep");
    a_sleep_cause: assert property ($changed(osc_run) |-> !$past(s_axi_awready) || !$past(s_axi_awready, 2))
        else $error("sleep state changed without a write");
    a_reset_values: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && osc_run && pc_out == 13'h0000)
        else $error("reset values wrong");
    c_sleep: cover property ($fell(osc_run));
    c_refused: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
    c_unmapped: cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule // exec_subset_props
bind exec_subset exec_subset_props u_props (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_run, .pc_out);
`default_nettype wire

// ### sim/exec_subset_test.sv
/* bench for the instruction subset executor: table of operations, then return, sleep and reset cases
   assumes the design files and the checker are compiled first */
`timescale 1ns/100ps
`default_nettype none
`include "exec_subset_map.svh"
module exec_subset_test;
    typedef struct packed {
        logic [3:0] op;
        logic d;
        logic [6:0] fa;
        logic [7:0] k, acc, fv;
        logic [2:0] pre;
        logic [7:0] eacc, efile;
        logic [2:0] est;
    } row_t;
    // op, dest, file address, literal, acc, file value, flags before; acc, file, flags {z,dc,c} after
    row_t rows [10] = '{
        '{`OP_LIT_MINUS_ACC, 1'h0, 7'h01, 8'h05, 8'h05, 8'h99, 3'h0, 8'h00, 8'h99, 3'h7},
        '{`OP_LIT_MINUS_ACC, 1'h0, 7'h02, 8'h00, 8'h01, 8'h11, 3'h7, 8'hff, 8'h11, 3'h0},
        '{`OP_LIT_MINUS_ACC, 1'h0, 7'h04, 8'h10, 8'h20, 8'h00, 3'h5, 8'hf0, 8'h00, 3'h2},
        '{`OP_XOR_LIT_ACC, 1'h0, 7'h03, 8'hff, 8'hff, 8'h22, 3'h0, 8'h00, 8'h22, 3'h4},
        '{`OP_FILE_MINUS_ACC, 1'h0, 7'h7f, 8'h00, 8'h11, 8'h20, 3'h6, 8'h0f, 8'h20, 3'h1},
        '{`OP_FILE_MINUS_ACC, 1'h1, 7'h00, 8'h00, 8'h22, 8'h11, 3'h7, 8'h22, 8'hef, 3'h0},
        '{`OP_XOR_FILE_ACC, 1'h1, 7'h05, 8'h00, 8'h3c, 8'h3c, 3'h3, 8'h3c, 8'h00, 3'h7},
        '{`OP_XOR_FILE_ACC, 1'h0, 7'h06, 8'h00, 8'h02, 8'h01, 3'h4, 8'h03, 8'h01, 3'h0},
        '{`OP_NIBBLE_EXCHANGE, 1'h0, 7'h09, 8'h00, 8'h00, 8'ha5, 3'h5, 8'h5a, 8'ha5, 3'h5},
        '{`OP_NIBBLE_EXCHANGE, 1'h1, 7'h0a, 8'h00, 8'h77, 8'h3c, 3'h2, 8'h77, 8'hc3, 3'h2}};
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, osc_run;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata, data;
    logic [12:0] pc_out, pc_seen;
    int failures = 0;
    int check_count = 0;
    row_t r;
    exec_subset u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .osc_run, .pc_out);
    // free-running clock
    always #5 aclk = ~aclk;
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %0t mismatch seen %h expected %h", $time, s, e);
        end
    endtask
    // one write: address and data offered together, released as each is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #100000;
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ADDR_STATUS, data, resp);
        chk(data[4:0], 5'h18);
        chk(pc_out, 13'h0000);
        // table of data operations
        foreach (rows[i]) begin
            r = rows[i];
            wr(`ADDR_FILE_WIN, {17'h0, r.fa, r.fv}, resp);
            wr(`ADDR_ACC, {24'h0, r.acc}, resp);
            wr(`ADDR_STATUS, {29'h0, r.pre}, resp);
            wr(`ADDR_CMD, {8'h0, r.k, 1'h0, r.fa, 3'h0, r.d, r.op}, resp);
            rd(`ADDR_ACC, data, resp);
            chk(data[7:0], r.eacc);
            rd(`ADDR_FILE_WIN, data, resp);
            chk(data[7:0], r.efile);
            rd(`ADDR_STATUS, data, resp);
            chk(data[2:0], r.est);
        end
        // return loads pc from the pushed entry, flags kept
        wr(`ADDR_STACK, 32'h0123, resp);
        wr(`ADDR_CMD, {28'h0, `OP_RETURN}, resp);
        rd(`ADDR_STATUS, data, resp);
        chk(data[2:0], 3'h2);
        chk(pc_out, 13'h0123);
        // halt: watchdog cleared, timeout flag set, powerdown flag cleared, core asleep and refusing commands
        wr(`ADDR_CMD, {28'h0, `OP_HALT}, resp);
        rd(`ADDR_STATUS, data, resp);
        chk(data[5:3], 3'h6);
        chk(osc_run, 1'h0);
        rd(`ADDR_STACK, data, resp);
        chk(data[15:8], 8'h00);
        rd(`ADDR_WAKE, data, resp);
        chk(data[7:0], 8'h00);
        pc_seen = pc_out;
        wr(`ADDR_CMD, {28'h0, `OP_XOR_LIT_ACC}, resp);
        chk(resp, 2'h2);
        chk(pc_out, pc_seen);
        wr(8'h40, 32'h0, resp);
        chk(resp, 2'h3);
        rd(8'h40, data, resp);
        chk(resp, 2'h3);
        wr(`ADDR_WAKE, 32'h0, resp);
        rd(`ADDR_STATUS, data, resp);
        chk(osc_run, 1'h1);
        // a command with no byte strobe is refused and the core stays awake
        s_axi_wstrb <= 4'h0;
        wr(`ADDR_CMD, {28'h0, `OP_HALT}, resp);
        s_axi_wstrb <= 4'hf;
        chk(resp, 2'h2);
        rd(`ADDR_STATUS, data, resp);
        chk(data[5], 1'h0);
        // command readback gives the last accepted halt, program counter is writable
        rd(`ADDR_CMD, data, resp);
        chk(data, {28'h0, `OP_HALT});
        wr(`ADDR_PC, 32'h0042, resp);
        rd(`ADDR_PC, data, resp);
        chk(data[12:0], 13'h0042);
        chk(pc_out, 13'h0042);
        // reset in mid-run restores accumulator, flags and program counter
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`ADDR_STATUS, data, resp);
        chk(data[6:0], 7'h18);
        rd(`ADDR_ACC, data, resp);
        chk(data[7:0], 8'h00);
        chk(pc_out, 13'h0000);
        report_and_stop();
    end
endmodule // exec_subset_test
`default_nettype wire
